// ### sst_selftest_regs.sv
// Functional notes
// - address 0x0d reads second signature byte, read only
// - address 0x0e reads third signature byte, read only
// - address 0x0f reads fourth signature byte, read only
// - writing bit 0 of 0x10 as one starts self-test; zero does nothing
// - self-test finishes and signatures are ready within 250 ms
// - signatures 36 72 7f d6 for orientation one, 33 8e 24 6c for zero
// - 0x11 resets to zero; bit 7 picks 500 or 1000 cpi
// - 0x1a bits 2:0 select led current, reset zero
// - 0x1c reports burst on bit 4, spi bit 2, two-wire bit 0
// - 0x1d bit 7 sets motion pin polarity, zero means active low
// - mode codes: 00 run, 01 rest one, 10 rest two, 11 rest three
// - observation bits set every frame, a write clears them unless a frame refresh falls in the same cycle
// - writing 0x5a to soft reset restores every default
`timescale 1ns/1ps
`include "sst_defines.svh"
module sst_selftest_regs #(
  parameter int unsigned ST_CYCLES = `SST_SELFTEST_MS * `SST_CLK_KHZ,
  parameter int unsigned FRAME_CYC = `SST_FRAME_CYC
) (
  input  wire logic       clk_sys,        // system clock, 50 MHz
  input  wire logic       rst_n,          // async reset, active low
  input  wire logic       sclk,           // serial clock pin
  input  wire logic       mosi,           // serial data in pin
  input  wire logic       ncs_n,          // chip select pin, active low
  input  wire logic       orient,         // mounting orientation pin
  input  wire logic       motion_present, // motion seen by navigation
  input  wire logic       burst_active,   // port in burst mode
  input  wire logic [1:0] power_state,    // current run/rest level
  output logic            miso,           // serial data out
  output logic            miso_oe,        // miso drive enable
  output logic            motion_pin,     // motion pin level
  output logic            res_1000,       // high selects 1000 cpi
  output logic [2:0]      drive_code,     // led drive current code
  output logic            selftest_busy   // self-test running
);
  sst_regbus_if       bus ();
  sst_pkg::sst_regs_s q;
  sst_pkg::sst_regs_s d;
  logic               frame_tick;
  logic               wr_ok;

  sst_spi_slave u_spi (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .sclk    (sclk),
    .mosi    (mosi),
    .ncs_n   (ncs_n),
    .miso    (miso),
    .miso_oe (miso_oe),
    .bus     (bus.spi)
  );

  // frame rate enable from a free divider
  assign frame_tick = (q.frame == 10'(FRAME_CYC - 1));
  // writes during the test are dropped; host must stay off anyway
  assign wr_ok      = bus.wr_stb && (q.st == sst_pkg::SST_ST_IDLE);

  // read mux, unmapped and reserved read as zero
  always_comb begin
    bus.rdata = `SST_REG_RST;
    case (bus.addr)
      `SST_ADDR_RES0:    bus.rdata = q.sig[0];
      `SST_ADDR_RES1:    bus.rdata = q.sig[1];
      `SST_ADDR_RES2:    bus.rdata = q.sig[2];
      `SST_ADDR_RES3:    bus.rdata = q.sig[3];
      `SST_ADDR_CFG:     bus.rdata = {q.res, 7'h00};
      `SST_ADDR_LED:     bus.rdata = {5'h00, q.led};
      `SST_ADDR_IFSTATE: bus.rdata = {3'h0, burst_active, 4'h4};
      `SST_ADDR_OBS:     bus.rdata = {q.obs, 6'h00};
      default:           bus.rdata = `SST_REG_RST;
    endcase
  end

  // register bank and self-test sequencer
  always_comb begin
    d          = q;
    d.orient_s = {q.orient_s[0], orient};
    d.frame    = frame_tick ? 10'h000 : q.frame + 10'h001;
    if (wr_ok) begin
      case (bus.addr)
        `SST_ADDR_LAUNCH: begin
          if (bus.wdata[`SST_ST_EN_BIT]) begin
            d.st  = sst_pkg::SST_ST_RUN;
            d.cnt = 24'h00_0000;
          end
        end
        `SST_ADDR_CFG:    d.res = bus.wdata[`SST_RES_BIT];
        `SST_ADDR_LED:    d.led = bus.wdata[2:0];
        `SST_ADDR_MOTION: d.pol = bus.wdata[`SST_POL_BIT];
        `SST_ADDR_OBS:    d.obs = 2'h0;
        `SST_ADDR_SOFTRST: begin
          if (bus.wdata == `SST_SOFTRST_KEY) begin
            d          = '0;
            d.orient_s = {q.orient_s[0], orient};
          end
        end
        default: ;
      endcase
    end
    // frame refresh beats a clearing write in the same cycle
    if (frame_tick) begin
      d.obs = power_state;
    end
    case (q.st)
      sst_pkg::SST_ST_RUN: begin
        d.cnt = q.cnt + 24'h00_0001;
        if (q.cnt == 24'(ST_CYCLES - 1)) begin
          d.st  = sst_pkg::SST_ST_IDLE;
          d.sig = q.orient_s[1] ? `SST_SIG1 : `SST_SIG0;
        end
      end
      default: ;
    endcase
    d.mpin = d.pol ? motion_present : ~motion_present;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q      <= '0;
      q.mpin <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign motion_pin    = q.mpin;
  assign res_1000      = q.res;
  assign drive_code    = q.led;
  assign selftest_busy = (q.st == sst_pkg::SST_ST_RUN);

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_launch;
    wr_ok && bus.addr == `SST_ADDR_LAUNCH && bus.wdata[0];
  endsequence
  sequence s_finish;
    $fell(selftest_busy);
  endsequence
  sequence s_softrst;
    wr_ok && bus.addr == `SST_ADDR_SOFTRST && bus.wdata == 8'h5a;
  endsequence

  launch_starts_a: assert property (s_launch |=> selftest_busy [*3])
    else $error("self-test did not start");
  launch_zero_a: assert property (wr_ok && bus.addr == `SST_ADDR_LAUNCH
      && !bus.wdata[0] |=> !selftest_busy)
    else $error("self-test started on zero");
  test_bound_a: assert property (selftest_busy |->
      q.cnt < 24'(ST_CYCLES))
    else $error("self-test overran");
  sig_orient_a: assert property (s_finish |-> q.sig ==
      ($past(q.orient_s[1]) ? `SST_SIG1 : `SST_SIG0))
    else $error("signature wrong for orientation");
  sig_read_a: assert property (bus.rd_stb && bus.addr == 7'h0f
      |-> bus.rdata == q.sig[3])
    else $error("fourth signature byte misread");
  res_write_a: assert property (wr_ok && bus.addr == `SST_ADDR_CFG
      |=> res_1000 == $past(bus.wdata[7]))
    else $error("resolution bit not stored");
  pol_motion_a: assert property (##1 motion_pin ==
      (q.pol ? $past(motion_present) : !$past(motion_present)))
    else $error("motion pin polarity wrong");
  obs_clear_a: assert property (wr_ok && bus.addr == `SST_ADDR_OBS
      && !frame_tick |=> q.obs == 2'h0)
    else $error("observation not cleared");
  softrst_a: assert property (s_softrst |=> !res_1000
      && drive_code == 3'h0 && !q.pol)
    else $error("soft reset left settings");
  reserved_rd_a: assert property (bus.addr inside {[7'h12:7'h19],
      7'h1b, [7'h1e:7'h2d]} |-> bus.rdata == 8'h00)
    else $error("reserved address read nonzero");
endmodule

// ### sst_defines.svh
`ifndef SST_DEFINES_SVH
`define SST_DEFINES_SVH

// register addresses on the serial port
`define SST_ADDR_RES0    7'h0c
`define SST_ADDR_RES1    7'h0d
`define SST_ADDR_RES2    7'h0e
`define SST_ADDR_RES3    7'h0f
`define SST_ADDR_LAUNCH  7'h10
`define SST_ADDR_CFG     7'h11
`define SST_ADDR_LED     7'h1a
`define SST_ADDR_IFSTATE 7'h1c
`define SST_ADDR_MOTION  7'h1d
`define SST_ADDR_OBS     7'h2e
`define SST_ADDR_SOFTRST 7'h3a

// field positions
`define SST_ST_EN_BIT    0
`define SST_RES_BIT      7
`define SST_POL_BIT      7
`define SST_IF_BURST_BIT 4
`define SST_IF_SPI_BIT   2
`define SST_IF_TWI_BIT   0

// values and reset values
`define SST_SOFTRST_KEY  8'h5a
`define SST_REG_RST      8'h00

// signatures, orientation one then orientation zero
`define SST_SIG1 {8'hd6, 8'h7f, 8'h72, 8'h36}
`define SST_SIG0 {8'h6c, 8'h24, 8'h8e, 8'h33}

// timing
`define SST_SELFTEST_MS  250
`define SST_CLK_KHZ      50000
`define SST_FRAME_CYC    1000

`endif

// ### sst_pkg.sv
package sst_pkg;

  typedef enum logic {SST_ST_IDLE, SST_ST_RUN} sst_st_e;

  // serial engine state
  typedef struct packed {
    logic [2:0] sclk_s;
    logic [1:0] mosi_s;
    logic [1:0] ncs_s;
    logic [3:0] cnt;
    logic [6:0] shin;
    logic       rw;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] tx;
    logic       miso;
    logic       oe;
    logic       wr;
    logic       rd;
  } sst_spi_s;

  // register bank state
  typedef struct packed {
    logic [1:0]      orient_s;
    sst_st_e         st;
    logic [23:0]     cnt;
    logic [3:0][7:0] sig;
    logic            res;
    logic [2:0]      led;
    logic            pol;
    logic [1:0]      obs;
    logic [9:0]      frame;
    logic            mpin;
  } sst_regs_s;

endpackage

// ### sst_regbus_if.sv
`timescale 1ns/1ps
interface sst_regbus_if;
  logic       wr_stb;
  logic       rd_stb;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport spi  (output wr_stb, rd_stb, addr, wdata, input rdata);
  modport regs (input wr_stb, rd_stb, addr, wdata, output rdata);
endinterface

// ### sst_spi_slave.sv
`timescale 1ns/1ps
module sst_spi_slave (
  input  wire logic clk_sys, // system clock
  input  wire logic rst_n,   // async reset, active low
  input  wire logic sclk,    // serial clock pin
  input  wire logic mosi,    // serial data in pin
  input  wire logic ncs_n,   // chip select pin, active low
  output logic      miso,    // serial data out
  output logic      miso_oe, // high while driving miso
  sst_regbus_if.spi bus      // register strobes
);
  sst_pkg::sst_spi_s q;
  sst_pkg::sst_spi_s d;
  logic              rise;
  logic              fall;
  logic              bit_in;

  // edges taken from second and third sync stages only
  assign rise   = q.sclk_s[1] & ~q.sclk_s[2];
  assign fall   = ~q.sclk_s[1] & q.sclk_s[2];
  assign bit_in = q.mosi_s[1];

  // first byte {write, addr[6:0]}, second byte data, msb first
  always_comb begin
    d        = q;
    d.wr     = 1'b0;
    d.rd     = 1'b0;
    d.sclk_s = {q.sclk_s[1:0], sclk};
    d.mosi_s = {q.mosi_s[0], mosi};
    d.ncs_s  = {q.ncs_s[0], ncs_n};
    if (q.ncs_s[1]) begin
      d.cnt = 4'h0;
      d.oe  = 1'b0;
    end else begin
      if (rise) begin
        d.shin = {q.shin[5:0], bit_in};
        d.cnt  = q.cnt + 4'h1;
        if (q.cnt == 4'h7) begin
          d.rw   = q.shin[6];
          d.addr = {q.shin[5:0], bit_in};
          d.rd   = ~q.shin[6];
        end
        if (q.cnt == 4'hf && q.rw) begin
          d.wdata = {q.shin, bit_in};
          d.wr    = 1'b1;
        end
      end
      // read data shifts out on falling edges, host samples on rising
      if (fall && q.cnt[3] && !q.rw) begin
        d.miso = q.tx[7];
        d.tx   = {q.tx[6:0], 1'b0};
        d.oe   = 1'b1;
      end
    end
    // bank answers in the strobe cycle, well before the next fall
    if (q.rd) begin
      d.tx = bus.rdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q        <= '0;
      q.sclk_s <= 3'h7;
      q.ncs_s  <= 2'h3;
    end else begin
      q <= d;
    end
  end

  assign miso       = q.miso;
  assign miso_oe    = q.oe;
  assign bus.wr_stb = q.wr;
  assign bus.rd_stb = q.rd;
  assign bus.addr   = q.addr;
  assign bus.wdata  = q.wdata;
endmodule

// ### sst_host_model.sv
`timescale 1ns/1ps
module sst_host_model (
  input  wire logic clk_sys, // system clock
  input  wire logic miso,    // serial data from device
  output logic      sclk,    // serial clock, idle high
  output logic      mosi,    // serial data to device
  output logic      ncs_n    // chip select, active low
);
  // port idle: clock high, device deselected
  initial begin
    sclk  = 1'b1;
    mosi  = 1'b0;
    ncs_n = 1'b1;
  end
  // address byte then data byte, msb first, 8 clk per bit
  task automatic xfer(input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    logic [15:0] v;
    v = {a, d};
    q = 8'h00;
    @(posedge clk_sys) ncs_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    for (int i = 15; i >= 0; i--) begin
      sclk <= 1'b0;
      mosi <= v[i];
      repeat (4) @(posedge clk_sys);
      sclk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      // late in the high phase: miso has surely settled
      if (i < 8) q[i] = miso;
    end
    ncs_n <= 1'b1;
    mosi  <= ~mosi; // a released line must not keep the last bit
    repeat (8) @(posedge clk_sys);
  endtask
endmodule

// ### tb_sensor_selftest_config_regs.sv
`timescale 1ns/1ps
module tb_sensor_selftest_config_regs;
  localparam int unsigned ST_CYC = 200;
  logic       clk_sys, rst_n, sclk, mosi, ncs_n, orient, motion_present;
  logic       burst_active, miso, miso_oe, motion_pin, res_1000;
  logic       selftest_busy;
  logic [1:0] power_state;
  logic [2:0] drive_code;
  int         n_errors, checks_done, cyc;
  logic [7:0] sig [2][4] = '{'{8'h33, 8'h8e, 8'h24, 8'h6c},
                             '{8'h36, 8'h72, 8'h7f, 8'hd6}};
  logic [6:0] rsv [8] = '{7'h0d, 7'h0e, 7'h0f, 7'h12, 7'h19, 7'h1b,
                          7'h1e, 7'h2d};
  logic [2:0] led [3] = '{3'h0, 3'h3, 3'h5};

  sst_selftest_regs #(.ST_CYCLES(ST_CYC), .FRAME_CYC(20))
  u_sst_selftest_regs (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk),
    .mosi(mosi), .ncs_n(ncs_n), .orient(orient),
    .motion_present(motion_present), .burst_active(burst_active),
    .power_state(power_state), .miso(miso), .miso_oe(miso_oe),
    .motion_pin(motion_pin), .res_1000(res_1000),
    .drive_code(drive_code), .selftest_busy(selftest_busy));
  sst_host_model u_sst_host_model (.clk_sys(clk_sys), .miso(miso),
    .sclk(sclk), .mosi(mosi), .ncs_n(ncs_n));

  // 50 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // hang guard, well above the whole sequence
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_sst_host_model.xfer({1'b1, a}, d, q);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] q;
    u_sst_host_model.xfer({1'b0, a}, 8'h00, q);
    chk(q, e);
  endtask

  task automatic t_reset();
    rd(7'h11, 8'h00);
    rd(7'h1a, 8'h00);
    chk({7'h00, miso_oe}, 8'h00);
    chk({7'h00, motion_pin}, 8'h01);
    $display("test reset values done");
  endtask
  task automatic t_cfg();
    wr(7'h11, 8'hff);
    chk({7'h00, res_1000}, 8'h01);
    rd(7'h11, 8'h80);
    foreach (led[i]) begin
      wr(7'h1a, {5'h1f, led[i]});
      chk({5'h00, drive_code}, {5'h00, led[i]});
      rd(7'h1a, {5'h00, led[i]});
    end
    $display("test config done");
  endtask
  task automatic t_motion();
    @(posedge clk_sys) motion_present <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk({7'h00, motion_pin}, 8'h00);
    wr(7'h1d, 8'h80);
    chk({7'h00, motion_pin}, 8'h01);
    rd(7'h1d, 8'h00);
    @(posedge clk_sys) motion_present <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk({7'h00, motion_pin}, 8'h00);
    $display("test motion polarity done");
  endtask
  task automatic t_misc();
    for (int b = 0; b < 2; b++) begin
      @(posedge clk_sys) burst_active <= b[0];
      rd(7'h1c, {3'h0, b[0], 4'h4});
    end
    foreach (rsv[i]) begin
      wr(rsv[i], 8'hff);
      rd(rsv[i], 8'h00);
    end
    // frame loads mode into bits 7:6 while the level is held
    for (int p = 0; p < 4; p++) begin
      @(posedge clk_sys) power_state <= p[1:0];
      repeat (30) @(posedge clk_sys);
      wr(7'h2e, 8'hff);
      rd(7'h2e, {p[1:0], 6'h00});
    end
    $display("test status and reserved done");
  endtask
  task automatic t_selftest(input int o);
    @(posedge clk_sys) orient <= o[0];
    wr(7'h10, 8'h00);
    chk({7'h00, selftest_busy}, 8'h00);
    wr(7'h3a, 8'h5a);
    chk({7'h00, res_1000}, 8'h00);
    wr(7'h60, 8'hf6);
    wr(7'h73, 8'haa);
    wr(7'h63, 8'hc4);
    wr(7'h10, 8'h01);
    chk({7'h00, selftest_busy}, 8'h01);
    repeat (ST_CYC) @(posedge clk_sys);
    chk({7'h00, selftest_busy}, 8'h00);
    for (int i = 0; i < 4; i++) rd(7'(7'h0c + i), sig[o][i]);
    wr(7'h3a, 8'h5a);
    rd(7'h0d, 8'h00);
    $display("test self-test orient %0d done", o);
  endtask

  // reset, then every scenario in turn
  initial begin
    rst_n = 1'b0;
    orient = 1'b1;
    motion_present = 1'b0;
    burst_active = 1'b0;
    power_state = 2'b00;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_cfg();
    t_motion();
    t_misc();
    t_selftest(1);
    t_selftest(0);
    give_verdict();
  end
endmodule
